// ==== hw/bpc_ctrl.sv ====
// control core: axi4-lite registers, low-power state machine, nv programming
// assumes synchronous pins, one 40 MHz clock, async active-low reset
`timescale 1ns/1ps
`include "bpc_consts.svh"

// How it works
// - output peak amplitude scales linearly with peak duty value
// - peak duty is the highest duty cycle within one revolution
// - one phase grounded while the other two are modulated
// - either low-power state stops driving the motor outputs
// - sleep: regulator and serial off, volatile registers back to default
// - standby: regulator on, registers kept, serial still answers
// - inhibit bit set blocks entering sleep or standby
// - setting inhibit while asleep does not wake the device
// - status bit 6 at 0x10 high while in standby; reads in sleep return zero with error
// - pwm mode: pin low dwell enters, pin high dwell exits
// - analog mode: thresholds with dwell; sleep exit above standby exit
// - serial mode: speed field zero for dwell enters low power
// - serial mode: nonzero speed field for dwell leaves standby
// - serial command cannot wake sleep; host must use speed pin
// - 96-bit nv store copied into parameter registers
// - unlock key 0xb6 then write-start bit starts programming
// - programming lasts about 24 ms then write-start clears itself
// - resistance code is 4-bit mantissa shifted by 3-bit exponent
// - code 0x7f decodes to 1920; below 3 is unsupported
// - resistance from first parameter register, bemf from second
// - bemf code decodes the same way, value 1090 per unit
// - peak duty derived from analog, pwm or serial speed source
module bpc_ctrl #(
  parameter int unsigned DWELL_CYC = `BPC_DWELL_CYC,
  parameter int unsigned NV_PROG_CYC = `BPC_NV_PROG_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // speed pin: digital level and analog code
  input wire logic speed_pin_level,
  input wire logic [7:0] speed_pin_analog,
  input wire logic [1:0] speed_mode_sel,
  // motor and regulator
  output logic [2:0] phase_pwm,
  output logic [1:0] grounded_phase,
  output logic regulator_en
);
  bpc_drive_if drv ();

  logic [7:0] nv_mem_q [`BPC_NV_WORDS];
  logic [7:0] param_q [`BPC_NV_WORDS];
  logic [8:0] serial_speed_command_q;
  logic [7:0] program_unlock_key_q;
  logic low_power_inhibit_q;
  logic sleep_variant_q;
  logic nv_write_go_q;
  logic param_load_sel_q;
  logic [25:0] nv_cnt_q;
  logic [25:0] dwell_q;
  logic [8:0] pwm_hi_q;
  logic [8:0] pwm_meas_q;
  logic [8:0] pwm_pos_q;
  logic [8:0] duty_q;
  logic [10:0] rm_value;
  logic [10:0] kt_value;
  bpc_pkg::bpc_pwr_t pwr_q;
  logic [7:0] aw_q;
  logic aw_have_q;
  logic [31:0] w_q;
  logic w_have_q;
  logic wr_fire;
  logic serial_on;
  logic enter_cond;
  logic exit_cond;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [1:0] reload_q;

  // ****************************************
  // axi4-lite write path
  // ****************************************

  // address and data captured independently; response after both
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                              {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= serial_on ? 2'h0 : 2'h2; // serial off in sleep
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;

  // serial interface answers in run and standby only
  assign serial_on = (pwr_q != bpc_pkg::BPC_PWR_SLEEP);

  // ****************************************
  // control registers
  // ****************************************

  // volatile control; sleep restores defaults
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      serial_speed_command_q <= 9'h000;
      program_unlock_key_q <= 8'h00;
      low_power_inhibit_q <= 1'b0;
      sleep_variant_q <= 1'b0;
      param_load_sel_q <= 1'b0;
    end else if (pwr_q == bpc_pkg::BPC_PWR_SLEEP) begin
      serial_speed_command_q <= 9'h000;
      program_unlock_key_q <= 8'h00;
      low_power_inhibit_q <= 1'b0;
      sleep_variant_q <= 1'b0;
      param_load_sel_q <= 1'b0;
    end else if (wr_fire) begin
      unique case (aw_q[7:2])
        `BPC_OFF_SPEED: serial_speed_command_q <= w_q[8:0];
        `BPC_OFF_DEVICE_CONTROL_REG: begin
          program_unlock_key_q <= w_q[7:0];
          low_power_inhibit_q <= w_q[`BPC_DEV_INHIBIT_BIT];
          sleep_variant_q <= w_q[`BPC_DEV_SLEEPVAR_BIT];
        end
        `BPC_OFF_NVCTRL: param_load_sel_q <= w_q[`BPC_NV_LOAD_BIT];
        default: ;
      endcase
    end
  end

  // parameter registers: loaded from nv store, or written by host
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `BPC_NV_WORDS; i++) param_q[i] <= 8'h00;
    end else if (reload_q != 2'h0) begin
      for (int i = 0; i < `BPC_NV_WORDS; i++) param_q[i] <= nv_mem_q[i];
    end else if (wr_fire && aw_q[7:2] >= `BPC_OFF_PARAM_LO
                 && aw_q[7:2] <= `BPC_OFF_PARAM_HI) begin
      param_q[4'(aw_q[7:2] - `BPC_OFF_PARAM_LO)] <= w_q[7:0];
    end
  end

  // copy nv into parameters after reset and on sleep wake
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reload_q <= 2'h1;
    end else begin
      reload_q <= (pwr_q == bpc_pkg::BPC_PWR_SLEEP) ? 2'h2 : 2'h0;
    end
  end

  // ****************************************
  // nv programming sequencer
  // ****************************************

  // go only with key present; bit self-clears after program time
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nv_write_go_q <= 1'b0;
      nv_cnt_q <= 26'h0000000;
    end else if (nv_write_go_q) begin
      if (nv_cnt_q == 26'(NV_PROG_CYC - 1)) begin
        nv_write_go_q <= 1'b0;
        nv_cnt_q <= 26'h0000000;
      end else begin
        nv_cnt_q <= nv_cnt_q + 26'h0000001;
      end
    end else if (wr_fire && serial_on && aw_q[7:2] == `BPC_OFF_NVCTRL && w_q[`BPC_NV_GO_BIT]
                 && program_unlock_key_q == `BPC_UNLOCK_KEY) begin
      nv_write_go_q <= 1'b1;
    end
  end

  // nv array committed at end of programming when load bit set, untouched otherwise
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `BPC_NV_WORDS; i++) nv_mem_q[i] <= 8'h00;
    end else if (nv_write_go_q && nv_cnt_q == 26'(NV_PROG_CYC - 1) && param_load_sel_q) begin
      for (int i = 0; i < `BPC_NV_WORDS; i++) nv_mem_q[i] <= param_q[i];
    end
  end

  // ****************************************
  // speed command to peak duty
  // ****************************************

  // pwm pin duty measured over a fixed window
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_pos_q <= 9'h000;
      pwm_hi_q <= 9'h000;
      pwm_meas_q <= 9'h000;
    end else begin
      pwm_pos_q <= pwm_pos_q + 9'h001;
      if (pwm_pos_q == 9'h1ff) begin
        pwm_meas_q <= pwm_hi_q;
        pwm_hi_q <= 9'h000; // 511 samples a window, so full high cannot wrap
      end else begin
        pwm_hi_q <= pwm_hi_q + {8'h00, speed_pin_level};
      end
    end
  end

  // source select for peak duty
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      duty_q <= 9'h000;
    end else begin
      unique case (speed_mode_sel)
        2'h1: duty_q <= pwm_meas_q;
        2'h2: duty_q <= serial_speed_command_q;
        default: duty_q <= {speed_pin_analog, speed_pin_analog[7]};
      endcase
    end
  end
  assign drv.peak_duty_output = duty_q; // full scale means full supply peak
  assign drv.drive_en = (pwr_q == bpc_pkg::BPC_PWR_RUN);

  // ****************************************
  // low-power state machine
  // ****************************************

  // entry and exit conditions per speed mode
  always_comb begin
    unique case (speed_mode_sel)
      2'h1: begin
        enter_cond = !speed_pin_level;
        exit_cond = speed_pin_level;
      end
      2'h2: begin
        enter_cond = (serial_speed_command_q == 9'h000);
        exit_cond = (pwr_q == bpc_pkg::BPC_PWR_SLEEP) ? speed_pin_level
                    : (serial_speed_command_q != 9'h000);
      end
      default: begin
        enter_cond = speed_pin_analog < (sleep_variant_q ? `BPC_ANA_EN_SL : `BPC_ANA_EN_SB);
        exit_cond = (pwr_q == bpc_pkg::BPC_PWR_SLEEP) ? (speed_pin_analog > `BPC_ANA_EX_SL)
                    : (speed_pin_analog > `BPC_ANA_EX_SB);
      end
    endcase
  end

  // one dwell timer; restarts when its condition breaks
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dwell_q <= 26'h0000000;
      pwr_q <= bpc_pkg::BPC_PWR_RUN;
    end else begin
      unique case (pwr_q)
        bpc_pkg::BPC_PWR_RUN: begin
          if (!enter_cond || low_power_inhibit_q) begin
            dwell_q <= 26'h0000000;
          end else if (dwell_q == 26'(DWELL_CYC - 1)) begin
            dwell_q <= 26'h0000000;
            pwr_q <= sleep_variant_q ? bpc_pkg::BPC_PWR_SLEEP : bpc_pkg::BPC_PWR_STANDBY;
          end else begin
            dwell_q <= dwell_q + 26'h0000001;
          end
        end
        default: begin
          // inhibit not consulted here, only exit condition wakes
          if (!exit_cond) begin
            dwell_q <= 26'h0000000;
          end else if (dwell_q == 26'(DWELL_CYC - 1)) begin
            dwell_q <= 26'h0000000;
            pwr_q <= bpc_pkg::BPC_PWR_RUN;
          end else begin
            dwell_q <= dwell_q + 26'h0000001;
          end
        end
      endcase
    end
  end

  // ****************************************
  // read path
  // ****************************************

  // parameter decode from first and second parameter registers
  bpc_param_decode u_dec (
    .rm_code(param_q[0][6:0]),
    .kt_code(param_q[1][6:0]),
    .rm_value(rm_value),
    .kt_value(kt_value)
  );

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:2] >= `BPC_OFF_PARAM_LO && s_axi_araddr[7:2] <= `BPC_OFF_PARAM_HI) begin
      rd_val = {24'h000000, param_q[4'(s_axi_araddr[7:2] - `BPC_OFF_PARAM_LO)]};
    end else begin
      unique case (s_axi_araddr[7:2])
        `BPC_OFF_SPEED: rd_val = {23'h000000, serial_speed_command_q};
        `BPC_OFF_DEVICE_CONTROL_REG: rd_val = {22'h000000, sleep_variant_q, low_power_inhibit_q,
                                   program_unlock_key_q};
        `BPC_OFF_NVCTRL: rd_val = {30'h00000000, param_load_sel_q, nv_write_go_q};
        // low rm value flagged unsupported in bit 31
        `BPC_OFF_DECODE: rd_val = {rm_value < `BPC_RM_MIN, 4'h0, kt_value, 5'h00, rm_value};
        `BPC_OFF_STATUS: rd_val = {25'h0000000, pwr_q != bpc_pkg::BPC_PWR_RUN, 6'h00};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // one read at a time, answered the cycle after address taken
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= serial_on ? rd_val : 32'h0000_0000;
      s_axi_rresp <= (!serial_on || !rd_ok) ? 2'h2 : 2'h0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ****************************************
  // outputs
  // ****************************************

  bpc_modulator u_mod (
    .core_clk(core_clk),
    .nrst(nrst),
    .drv(drv)
  );
  assign phase_pwm = drv.phase_pwm;
  assign grounded_phase = drv.grounded_phase;

  // regulator stays on except in sleep
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regulator_en <= 1'b1;
    end else begin
      regulator_en <= (pwr_q != bpc_pkg::BPC_PWR_SLEEP);
    end
  end
endmodule

// ==== hw/bpc_consts.svh ====
// constants for the motor power-state and parameter control block
// assumes inclusion by bare name from design files under hw/
`ifndef BPC_CONSTS_SVH
`define BPC_CONSTS_SVH

// ****************************************
// register word indices; byte address is four times the index
// ****************************************
`define BPC_OFF_STATUS 6'h10
`define BPC_OFF_SPEED 6'h00
`define BPC_OFF_DEVICE_CONTROL_REG 6'h01
`define BPC_OFF_NVCTRL 6'h02
`define BPC_OFF_DECODE 6'h03
`define BPC_OFF_PARAM_LO 6'h20
`define BPC_OFF_PARAM_HI 6'h2b
`define BPC_NV_WORDS 12

// ****************************************
// field positions and keys
// ****************************************
`define BPC_STAT_LOWPWR_BIT 6
`define BPC_UNLOCK_KEY 8'hb6
`define BPC_DEV_INHIBIT_BIT 8
`define BPC_DEV_SLEEPVAR_BIT 9
`define BPC_NV_GO_BIT 0
`define BPC_NV_LOAD_BIT 1

// ****************************************
// thresholds (8-bit analog code) and timing
// ****************************************
`define BPC_ANA_EN_SB 8'h10
`define BPC_ANA_EX_SB 8'h20
`define BPC_ANA_EN_SL 8'h10
`define BPC_ANA_EX_SL 8'h40
`define BPC_CLK_MHZ 40
`define BPC_DWELL_US 1000
`define BPC_DWELL_CYC (`BPC_DWELL_US * `BPC_CLK_MHZ)
`define BPC_NV_PROG_MS 24
`define BPC_NV_PROG_CYC (`BPC_NV_PROG_MS * 1000 * `BPC_CLK_MHZ)
`define BPC_PWM_PERIOD 512
`define BPC_RM_MIN 11'h003

`endif

// ==== hw/bpc_pkg.sv ====
// types shared by the control block modules
// assumes nothing beyond a systemverilog compiler
package bpc_pkg;
  typedef enum logic [1:0] {
    BPC_SRC_ANALOG,
    BPC_SRC_PWM,
    BPC_SRC_SERIAL
  } bpc_src_t;
  typedef enum logic [1:0] {
    BPC_PWR_RUN,
    BPC_PWR_STANDBY,
    BPC_PWR_SLEEP
  } bpc_pwr_t;
endpackage

// ==== hw/bpc_drive_if.sv ====
// carrier between the control core and the phase modulator
// assumes one clock domain
`timescale 1ns/1ps
interface bpc_drive_if;
  logic [8:0] peak_duty_output;
  logic drive_en;
  logic [2:0] phase_pwm;
  logic [1:0] grounded_phase;
  modport core (output peak_duty_output, output drive_en, input phase_pwm, input grounded_phase);
  modport mod (input peak_duty_output, input drive_en, output phase_pwm, output grounded_phase);
endinterface

// ==== hw/bpc_modulator.sv ====
// three-phase modulator with one phase clamped to ground per sector
// assumes drive_if from the core, single clock, async active-low reset
`timescale 1ns/1ps
`include "bpc_consts.svh"
module bpc_modulator (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // drive carrier
  bpc_drive_if.mod drv
);
  logic [8:0] cnt_q;
  logic [5:0] sec_q;
  logic [2:0] pwm_q;
  logic [1:0] gnd_q;
  logic [9:0] cmp_a;
  logic [9:0] cmp_b;

  // carrier and sector counters; sector steps each pwm period
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 9'h000;
      sec_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 9'h001;
      if (cnt_q == 9'h1ff) begin
        sec_q <= (sec_q == 6'h2f) ? 6'h00 : sec_q + 6'h01;
      end
    end
  end

  // crude third-harmonic shape: two active phases scaled by peak duty
  always_comb begin
    cmp_a = {1'b0, drv.peak_duty_output};
    cmp_b = {1'b0, drv.peak_duty_output} >> 1;
  end

  // grounded phase rotates a third of a revolution at a time
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_q <= 3'h0;
      gnd_q <= 2'h0;
    end else if (!drv.drive_en) begin
      pwm_q <= 3'h0; // outputs idle in low power
      gnd_q <= 2'h0;
    end else begin
      gnd_q <= (sec_q < 6'h10) ? 2'h0 : (sec_q < 6'h20) ? 2'h1 : 2'h2;
      // peak duty sets highest on-time in the revolution
      pwm_q[0] <= (sec_q >= 6'h10) && ({1'b0, cnt_q} < cmp_a);
      pwm_q[1] <= (sec_q < 6'h10 || sec_q >= 6'h20) && ({1'b0, cnt_q} < cmp_b);
      pwm_q[2] <= (sec_q < 6'h20) && ({1'b0, cnt_q} < cmp_a);
    end
  end

  assign drv.phase_pwm = pwm_q;
  assign drv.grounded_phase = gnd_q;
endmodule

// ==== hw/bpc_param_decode.sv ====
// mantissa/exponent decoder for the two motor parameter codes
// assumes 7-bit codes, purely combinational
`timescale 1ns/1ps
module bpc_param_decode (
  // codes
  input wire logic [6:0] rm_code,
  input wire logic [6:0] kt_code,
  // decoded values
  output logic [10:0] rm_value,
  output logic [10:0] kt_value
);
  // value = mantissa << exponent; 0x7f gives 1920
  always_comb begin
    rm_value = 11'({7'h00, rm_code[3:0]} << rm_code[6:4]);
    kt_value = 11'({7'h00, kt_code[3:0]} << kt_code[6:4]);
  end
endmodule

// ==== verif/bpc_ctrl_assertions.sv ====
// concurrent checks on the control core ports
// assumes the core's single clock and async active-low reset
`timescale 1ns/1ps
// ****************************************
// checker module
// ****************************************
module bpc_ctrl_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and motor side
  input wire logic speed_pin_level,
  input wire logic [1:0] speed_mode_sel,
  input wire logic [2:0] phase_pwm,
  input wire logic [1:0] grounded_phase,
  input wire logic regulator_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // bus answers stand until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ar_free;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_ar_free: assert property (p_ar_free) else $error("read address ready wrong");
  // write answer two edges after both halves are taken, read answer one
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read response late");
  // the clamped phase never switches
  property p_ground_clamp;
    grounded_phase != 2'd3 && phase_pwm[grounded_phase] == 1'b0;
  endproperty
  a_ground_clamp: assert property (p_ground_clamp) else $error("clamped phase driven");
  // one cycle of slack for the modulator flop
  property p_lp_no_drive;
    !regulator_en && $past(regulator_en) == 1'b0 |-> phase_pwm == 3'b000;
  endproperty
  a_lp_no_drive: assert property (p_lp_no_drive) else $error("outputs driven asleep");
  // only a high speed pin wakes from sleep outside analog mode
  property p_wake_by_pin;
    $rose(regulator_en) && speed_mode_sel != 2'd0 |-> $past(speed_pin_level);
  endproperty
  a_wake_by_pin: assert property (p_wake_by_pin) else $error("woke without pin");
endmodule
bind bpc_ctrl bpc_ctrl_assertions bpc_ctrl_assertions_inst (
  .core_clk(core_clk), .nrst(nrst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .speed_pin_level(speed_pin_level), .speed_mode_sel(speed_mode_sel),
  .phase_pwm(phase_pwm), .grounded_phase(grounded_phase), .regulator_en(regulator_en)
);

// ==== verif/bpc_host_pins.sv ====
// host side of the speed pin: mode strap, digital level, analog code
// assumes commands from the bench, launched after the rising edge
`timescale 1ns/1ps
module bpc_host_pins (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // commands from the bench
  input wire logic [1:0] cmd_mode,
  input wire logic cmd_level,
  input wire logic [7:0] cmd_analog,
  // pins to the core
  output logic [1:0] speed_mode_sel,
  output logic speed_pin_level,
  output logic [7:0] speed_pin_analog
);
  // pins settle one edge after a command; reset leaves the motor running
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      speed_mode_sel <= 2'h0;
      speed_pin_level <= 1'b1;
      speed_pin_analog <= 8'h80;
    end else begin
      speed_mode_sel <= cmd_mode;
      speed_pin_level <= cmd_level; // wake from sleep by this pin in pwm and serial modes; analog mode uses the code
      speed_pin_analog <= cmd_analog;
    end
  end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the control core over axi4-lite
// assumes short dwell and programming counts set by parameter
`timescale 1ns/1ps
module testbench;
  localparam int DW = 8;
  localparam int NV = 16;
  logic core_clk, nrst;
  logic [7:0] s_axi_awaddr, s_axi_araddr, speed_pin_analog, cmd_analog;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, speed_pin_level, cmd_level;
  logic [1:0] s_axi_bresp, s_axi_rresp, speed_mode_sel, cmd_mode, grounded_phase, rs;
  logic [2:0] phase_pwm;
  logic regulator_en;
  logic [10:0] v;
  logic [7:0] codes [4] = '{8'h7f, 8'h02, 8'h58, 8'h01};
  logic [10:0] vals [4] = '{11'd1920, 11'd2, 11'd256, 11'd1};
  int err_total = 0;
  int num_checks = 0;
  bpc_ctrl #(.DWELL_CYC(DW), .NV_PROG_CYC(NV)) bpc_ctrl_inst (
    .core_clk(core_clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .speed_pin_level(speed_pin_level), .speed_pin_analog(speed_pin_analog),
    .speed_mode_sel(speed_mode_sel), .phase_pwm(phase_pwm),
    .grounded_phase(grounded_phase), .regulator_en(regulator_en));
  bpc_host_pins bpc_host_pins_inst (
    .core_clk(core_clk), .nrst(nrst), .cmd_mode(cmd_mode), .cmd_level(cmd_level),
    .cmd_analog(cmd_analog), .speed_mode_sel(speed_mode_sel),
    .speed_pin_level(speed_pin_level), .speed_pin_analog(speed_pin_analog));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // entered and left just after a rising edge; each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit got;
    n = 0;
    got = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!got && n < 200) begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        got = 1;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end else if (s_axi_bvalid) begin
        s_axi_bready <= 1'b1;
      end
    end
    if (!got) chk(32'h0, 32'h1);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    bit got;
    n = 0;
    got = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!got && n < 200) begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        got = 1;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end else if (s_axi_rvalid) begin
        s_axi_rready <= 1'b1;
      end
    end
    if (!got) chk(32'h0, 32'h1);
  endtask
  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // whole sequence needs about 300 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    finish_test;
  end
  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    cmd_mode = 2'h0;
    cmd_level = 1'b1;
    cmd_analog = 8'h80;
    cyc(3);
    nrst <= 1'b1;
    cyc(1);
    chk(regulator_en, 1'b1);
    rdr(8'h40);
    chk(rd, 32'h0);
    rdr(8'h3c);
    chk({rs, rd}, {2'h2, 32'h0});
    // decode table: mantissa shifted by exponent, flag below three
    foreach (codes[i]) begin
      v = vals[i];
      wr(8'h80, {24'h0, codes[i]});
      wr(8'h84, {24'h0, codes[i]});
      rdr(8'h0c);
      chk(rd, {v < 11'd3, 4'h0, v, 5'h0, v});
    end
    // start without the key is ignored
    wr(8'h08, 32'h3);
    rdr(8'h08);
    chk(rd & 32'h1, 32'h0);
    wr(8'h08, 32'h2);
    wr(8'h80, 32'h58);
    wr(8'h04, 32'hb6);
    wr(8'h08, 32'h3);
    rdr(8'h08);
    chk(rd & 32'h1, 32'h1);
    cyc(NV + 4);
    rdr(8'h08);
    chk(rd & 32'h1, 32'h0);
    // serial mode: zero speed enters standby, nonzero leaves
    wr(8'h00, 32'h0);
    cmd_mode <= 2'h2;
    cyc(DW + 6);
    rdr(8'h40);
    chk(rd & 32'h40, 32'h40);
    rdr(8'h04);
    chk(rd & 32'hff, 32'hb6);
    chk({regulator_en, phase_pwm}, 4'h8);
    wr(8'h00, 32'h100);
    cyc(DW + 6);
    rdr(8'h40);
    chk(rd & 32'h40, 32'h0);
    // inhibit blocks entry
    wr(8'h04, 32'h1b6);
    wr(8'h00, 32'h0);
    cyc(DW + 6);
    rdr(8'h40);
    chk(rd & 32'h40, 32'h0);
    // pwm mode, sleep variant: broken dwell restarts
    wr(8'h04, 32'h2b6);
    cmd_mode <= 2'h1;
    cyc(4);
    cmd_level <= 1'b0;
    cyc(DW - 2);
    cmd_level <= 1'b1;
    cyc(1);
    cmd_level <= 1'b0;
    cyc(DW - 2);
    cmd_level <= 1'b1;
    cyc(2);
    chk(regulator_en, 1'b1);
    cmd_level <= 1'b0;
    cyc(DW + 6);
    chk({regulator_en, phase_pwm}, 4'h0);
    wr(8'h00, 32'h100);
    chk(rs, 2'h2);
    cmd_level <= 1'b1;
    cyc(DW + 6);
    chk(regulator_en, 1'b1);
    rdr(8'h04);
    chk(rd, 32'h0);
    rdr(8'h80);
    chk(rd & 32'hff, 32'h58);
    // analog mode: low code enters standby, code above standby exit leaves
    cmd_mode <= 2'h0;
    cmd_analog <= 8'h08;
    cyc(DW + 6);
    rdr(8'h40);
    chk(rd & 32'h40, 32'h40);
    cmd_analog <= 8'h30;
    cyc(DW + 6);
    rdr(8'h40);
    chk(rd & 32'h40, 32'h0);
    finish_test;
  end
endmodule
